// >>> test/sart_axi_host.sv
// register bus master model standing in for the processor core
`timescale 1ns/1ps
module sart_axi_host (
  input  wire logic        clk_in,      // system clock
  output logic [7:0]       awaddr_out,  // write address
  output logic             awvalid_out, // write address valid
  input  wire logic        awready_in,  // write address ready
  output logic [31:0]      wdata_out,   // write data
  output logic [3:0]       wstrb_out,   // write byte enables
  output logic             wvalid_out,  // write data valid
  input  wire logic        wready_in,   // write data ready
  input  wire logic [1:0]  bresp_in,    // write response
  input  wire logic        bvalid_in,   // write response valid
  output logic             bready_out,  // write response ready
  output logic [7:0]       araddr_out,  // read address
  output logic             arvalid_out, // read address valid
  input  wire logic        arready_in,  // read address ready
  input  wire logic [31:0] rdata_in,    // read data
  input  wire logic [1:0]  rresp_in,    // read response
  input  wire logic        rvalid_in,   // read data valid
  output logic             rready_out   // read data ready
);
  initial {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out,
           bready_out, araddr_out, arvalid_out, rready_out} = '0;

  // each task starts on a fresh edge so no signal is assigned twice at once
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    awaddr_out  <= a;
    wdata_out   <= d;
    wstrb_out   <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out  <= 1'b1;
    bready_out  <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      // a taken item is inverted so a late sample by the slave shows up
      if (awvalid_out && awready_in) begin
        awvalid_out <= 1'b0;
        awaddr_out  <= ~a;
      end
      if (wvalid_out && wready_in) begin
        wvalid_out <= 1'b0;
        wdata_out  <= ~d;
      end
    end while (!bvalid_in && n < 200);
    r = bresp_in;
    bready_out <= 1'b0;
    if (n >= 200) begin
      sart_timer_tb_top.errors++;
      sart_timer_tb_top.finish_test();
    end
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr_out  <= a;
    arvalid_out <= 1'b1;
    rready_out  <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arvalid_out && arready_in) begin
        arvalid_out <= 1'b0;
        araddr_out  <= ~a;
      end
    end while (!rvalid_in && n < 200);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
    if (n >= 200) begin
      sart_timer_tb_top.errors++;
      sart_timer_tb_top.finish_test();
    end
  endtask : read
endmodule : sart_axi_host

// >>> test/sart_timer_tb_top.sv
// register-level testbench for the split auto-reload timer
`timescale 1ns/1ps
module sart_timer_tb_top;
  logic        clk_sys_in, resetn_in, ext_osc_in, osc_run, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  int          errors, check_count;

  sart_timer i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .ext_osc_in(ext_osc_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq));

  sart_axi_host i_host (.clk_in(clk_sys_in), .awaddr_out(awaddr),
    .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata),
    .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
    .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
    .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
    .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
    .rready_out(rready));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // oscillator toggles every second edge: one rise per 4 cycles
  initial begin
    ext_osc_in = 1'b0;
    forever begin
      repeat (2) @(posedge clk_sys_in);
      if (osc_run) ext_osc_in <= ~ext_osc_in;
    end
  end

  task automatic finish_test();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.write(a, d, r);
    chk_resp(r, sart_pkg::RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    i_host.read(a, v, r);
    chk_resp(r, sart_pkg::RESP_OKAY);
    chk_word(v & m, e);
  endtask : rd

  // counts under a running clock are only known to a window
  task automatic rd_rng(input logic [7:0] a, input logic [31:0] lo,
                        input logic [31:0] hi);
    i_host.read(a, v, r);
    chk_word({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask : rd_rng

  task automatic chk_irq(input logic e);
    @(posedge clk_sys_in);
    chk_word({31'h0, irq}, {31'h0, e});
  endtask : chk_irq

  initial begin
    resetn_in = 1'b0;
    osc_run = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(sart_pkg::OFF_CTRL, 32'h0);
    i_host.read(8'h3c, v, r);
    chk_resp(r, sart_pkg::RESP_SLVERR);
    i_host.write(8'h3c, 32'h55, r);
    chk_resp(r, sart_pkg::RESP_SLVERR);
    wr(sart_pkg::OFF_RL_LO, 32'h34);
    wr(sart_pkg::OFF_RL_HI, 32'h12);
    wr(sart_pkg::OFF_CNT_LO, 32'hf0);
    wr(sart_pkg::OFF_CNT_HI, 32'hff);
    rd(sart_pkg::OFF_RL_LO, 32'h34);
    rd(sart_pkg::OFF_CNT_HI, 32'hff);
    wr(sart_pkg::OFF_CLKSEL, 32'h1);
    wr(sart_pkg::OFF_IEN, 32'h1);
    wr(sart_pkg::OFF_IRQ_MASK, 32'h3);
    repeat (40) @(posedge clk_sys_in);
    rd(sart_pkg::OFF_CNT_LO, 32'hf0);
    rd(sart_pkg::OFF_CTRL, 32'h0);
    chk_irq(1'b0);
    wr(sart_pkg::OFF_CTRL, 32'h04);
    repeat (30) @(posedge clk_sys_in);
    rd(sart_pkg::OFF_CNT_HI, 32'h12);
    rd(sart_pkg::OFF_CTRL, 32'hc4);
    chk_irq(1'b1);
    repeat (100) @(posedge clk_sys_in);
    rd(sart_pkg::OFF_CTRL, 32'hc4);
    wr(sart_pkg::OFF_CTRL, 32'h00);
    wr(sart_pkg::OFF_IRQ_ST, 32'h2);
    chk_irq(1'b0);
    wr(sart_pkg::OFF_CTRL, 32'h20);
    chk_irq(1'b1);
    wr(sart_pkg::OFF_IRQ_MASK, 32'h2);
    chk_irq(1'b0);
    wr(sart_pkg::OFF_IRQ_ST, 32'h1);
    rd(sart_pkg::OFF_IRQ_ST, 32'h0);
    wr(sart_pkg::OFF_IRQ_MASK, 32'h3);
    wr(sart_pkg::OFF_CLKSEL, 32'h3);
    wr(sart_pkg::OFF_RL_LO, 32'ha0);
    wr(sart_pkg::OFF_RL_HI, 32'h50);
    wr(sart_pkg::OFF_CNT_LO, 32'hf8);
    wr(sart_pkg::OFF_CNT_HI, 32'hf8);
    wr(sart_pkg::OFF_CTRL, 32'h08);
    repeat (10) @(posedge clk_sys_in);
    rd_rng(sart_pkg::OFF_CNT_LO, 32'ha0, 32'hc0);
    rd(sart_pkg::OFF_CNT_HI, 32'hf8);
    rd(sart_pkg::OFF_CTRL, 32'h48);
    chk_irq(1'b0);
    wr(sart_pkg::OFF_IRQ_ST, 32'h3);
    wr(sart_pkg::OFF_CTRL, 32'h0c);
    repeat (15) @(posedge clk_sys_in);
    rd_rng(sart_pkg::OFF_CNT_HI, 32'h50, 32'h60);
    rd(sart_pkg::OFF_CTRL, 32'h8c, 32'hbf);
    chk_irq(1'b1);
    wr(sart_pkg::OFF_CTRL, 32'h28);
    repeat (110) @(posedge clk_sys_in);
    wr(sart_pkg::OFF_IRQ_ST, 32'h2);
    chk_irq(1'b1);
    wr(sart_pkg::OFF_CLKSEL, 32'h0);
    wr(sart_pkg::OFF_CTRL, 32'h08);
    wr(sart_pkg::OFF_CNT_LO, 32'h00);
    repeat (120) @(posedge clk_sys_in);
    rd_rng(sart_pkg::OFF_CNT_LO, 32'h9, 32'hb);
    osc_run <= 1'b1;
    wr(sart_pkg::OFF_CTRL, 32'h09);
    wr(sart_pkg::OFF_CNT_LO, 32'h00);
    repeat (320) @(posedge clk_sys_in);
    rd_rng(sart_pkg::OFF_CNT_LO, 32'h9, 32'hb);
    finish_test();
  end
endmodule : sart_timer_tb_top

// >>> verilog/sart_byte_cnt.sv
// one 8-bit count byte with software load and reload
`timescale 1ns/1ps
module sart_byte_cnt (
  input  wire logic       clk_sys_in,     // system clock
  input  wire logic       resetn_in,      // async reset, low
  input  wire logic       wr_en_in,       // software write strobe
  input  wire logic [7:0] wr_data_in,     // software write data
  input  wire logic       reload_in,      // load reload value
  input  wire logic [7:0] reload_val_in,  // reload value
  input  wire logic       inc_in,         // count one step
  output logic      [7:0] count_out       // current count
);
  // software wins so a write is never lost under a running timer
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_out <= sart_pkg::BYTE_ZERO;
    end else if (wr_en_in) begin
      count_out <= wr_data_in;
    end else if (reload_in) begin
      count_out <= reload_val_in;
    end else if (inc_in) begin
      count_out <= count_out + 8'h01;
    end
  end
endmodule : sart_byte_cnt

// >>> verilog/sart_pkg.sv
// shared constants and types for the split auto-reload timer
package sart_pkg;
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CNT_LO   = 8'h04;
  localparam logic [7:0] OFF_CNT_HI   = 8'h08;
  localparam logic [7:0] OFF_RL_LO    = 8'h0c;
  localparam logic [7:0] OFF_RL_HI    = 8'h10;
  localparam logic [7:0] OFF_CLKSEL   = 8'h14;
  localparam logic [7:0] OFF_IEN      = 8'h18;
  localparam logic [7:0] OFF_IRQ_ST   = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] BYTE_MAX     = 8'hff;
  localparam logic [1:0] PAIR_ZERO    = 2'h0;
  localparam int         SYS_DIV      = 12;
  localparam int         EXT_DIV      = 8;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [23:0] PAD_ZERO    = 24'h000000;

  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_interrupt_enable;
    logic slow_osc_capture_enable;
    logic split_mode_select;
    logic run_control;
    logic unused;
    logic external_clock_select;
  } sart_ctrl_type;

  localparam sart_ctrl_type CTRL_RESET = 8'h00;

  typedef struct packed {
    logic sys;
    logic sys_div12;
    logic ext_div8;
  } sart_tick_type;

  // bit 1 high byte, bit 0 low byte
  typedef struct packed {
    logic high;
    logic low;
  } sart_pair_type;
endpackage : sart_pkg

// >>> verilog/sart_tick_gen.sv
// clock enables: system clock, system clock / 12, external osc / 8
`timescale 1ns/1ps
module sart_tick_gen #(
  parameter int SYS_DIV_P = sart_pkg::SYS_DIV,
  parameter int EXT_DIV_P = sart_pkg::EXT_DIV
) (
  input  wire logic                   clk_sys_in,   // system clock
  input  wire logic                   resetn_in,    // async reset, low
  input  wire logic                   ext_osc_in,   // external oscillator pin
  output sart_pkg::sart_tick_type     ticks_out     // one-cycle enables
);
  localparam int SW = $clog2(SYS_DIV_P);
  localparam int EW = $clog2(EXT_DIV_P);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV_P - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV_P - 1);

  logic [SW-1:0] sys_cnt;
  logic [EW-1:0] ext_cnt;
  logic          sync1;
  logic          sync2;
  logic          sync3;
  logic          osc_level;
  logic          osc_rise;
  logic          div12_tick;
  logic          ext_tick;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sys_cnt    <= '0;
      div12_tick <= 1'b0;
    end else begin
      div12_tick <= (sys_cnt == SYS_LAST);
      sys_cnt    <= (sys_cnt == SYS_LAST) ? '0 : sys_cnt + 1'b1;
    end
  end

  // three stages; a change counts only once stages two and three agree
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= ext_osc_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign osc_rise = (sync2 == sync3) && sync3 && !osc_level;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_level <= 1'b0;
      ext_cnt   <= '0;
      ext_tick  <= 1'b0;
    end else begin
      if (sync2 == sync3) begin
        osc_level <= sync3;
      end
      ext_tick <= osc_rise && (ext_cnt == EXT_LAST);
      if (osc_rise) begin
        ext_cnt <= (ext_cnt == EXT_LAST) ? '0 : ext_cnt + 1'b1;
      end
    end
  end

  // one driver for the whole struct: sys, sys_div12, ext_div8
  assign ticks_out = {1'b1, div12_tick, ext_tick};
endmodule : sart_tick_gen

// >>> verilog/sart_timer.sv
// split auto-reload timer with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module sart_timer (
  input  wire logic        clk_sys_in,        // system clock, 100 MHz
  input  wire logic        resetn_in,         // async reset, low
  input  wire logic        ext_osc_in,        // external oscillator pin
  input  wire logic [7:0]  s_axi_awaddr_in,   // write address
  input  wire logic        s_axi_awvalid_in,  // write address valid
  output logic             s_axi_awready_out, // write address ready
  input  wire logic [31:0] s_axi_wdata_in,    // write data
  input  wire logic [3:0]  s_axi_wstrb_in,    // write byte enables
  input  wire logic        s_axi_wvalid_in,   // write data valid
  output logic             s_axi_wready_out,  // write data ready
  output logic [1:0]       s_axi_bresp_out,   // write response
  output logic             s_axi_bvalid_out,  // write response valid
  input  wire logic        s_axi_bready_in,   // write response ready
  input  wire logic [7:0]  s_axi_araddr_in,   // read address
  input  wire logic        s_axi_arvalid_in,  // read address valid
  output logic             s_axi_arready_out, // read address ready
  output logic [31:0]      s_axi_rdata_out,   // read data
  output logic [1:0]       s_axi_rresp_out,   // read response
  output logic             s_axi_rvalid_out,  // read data valid
  input  wire logic        s_axi_rready_in,   // read data ready
  output logic             irq_out            // level interrupt
);
  sart_pkg::sart_ctrl_type ctrl;
  sart_pkg::sart_tick_type ticks;
  sart_pkg::sart_pair_type clk_sel;
  sart_pkg::sart_pair_type irq_st;
  sart_pkg::sart_pair_type irq_mask;
  sart_pkg::sart_pair_type irq_set;
  sart_pkg::sart_pair_type w1c;
  logic                    timer_ien;
  logic [7:0]              cnt_lo;
  logic [7:0]              cnt_hi;
  logic [7:0]              rl_lo;
  logic [7:0]              rl_hi;

  logic [7:0]              aw_addr;
  logic                    aw_held;
  logic [7:0]              w_data;
  logic                    w_strb0;
  logic                    w_held;
  logic                    do_write;
  logic                    wr_hit;
  logic                    wr_ctrl;
  logic                    wr_cnt_lo;
  logic                    wr_cnt_hi;
  logic                    wr_rl_lo;
  logic                    wr_rl_hi;
  logic                    wr_clksel;
  logic                    wr_ien;
  logic                    wr_st;
  logic                    wr_mask;
  logic                    aw_mapped;
  logic                    ar_mapped;
  logic [7:0]              rd_byte;

  logic                    lo_tick;
  logic                    hi_tick;
  logic                    lo_inc;
  logic                    hi_inc;
  logic                    lo_wrap;
  logic                    hi_wrap;
  logic                    full_wrap;
  logic                    lo_reload;
  logic                    hi_reload;

  function automatic logic pick_tick(input logic fast_sel,
                                     input logic ext_sel,
                                     input sart_pkg::sart_tick_type t);
    if (fast_sel) begin
      pick_tick = t.sys;
    end else begin
      pick_tick = ext_sel ? t.ext_div8 : t.sys_div12;
    end
  endfunction : pick_tick

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == sart_pkg::OFF_CTRL)   || (a == sart_pkg::OFF_CNT_LO) ||
                (a == sart_pkg::OFF_CNT_HI) || (a == sart_pkg::OFF_RL_LO)  ||
                (a == sart_pkg::OFF_RL_HI)  || (a == sart_pkg::OFF_CLKSEL) ||
                (a == sart_pkg::OFF_IEN)    || (a == sart_pkg::OFF_IRQ_ST) ||
                (a == sart_pkg::OFF_IRQ_MASK);
  endfunction : is_mapped

  sart_tick_gen u_ticks (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .ext_osc_in (ext_osc_in),
    .ticks_out  (ticks)
  );

  // count control; 16-bit mode runs from the low byte clock select
  assign lo_tick = pick_tick(clk_sel.low, ctrl.external_clock_select,
                             ticks);
  assign hi_tick = pick_tick(clk_sel.high, ctrl.external_clock_select,
                             ticks);

  always_comb begin
    if (ctrl.split_mode_select) begin
      lo_inc    = lo_tick;
      lo_wrap   = lo_inc && (cnt_lo == sart_pkg::BYTE_MAX);
      hi_inc    = hi_tick && ctrl.run_control;
      hi_wrap   = hi_inc && (cnt_hi == sart_pkg::BYTE_MAX);
      full_wrap = 1'b0;
      lo_reload = lo_wrap;
      hi_reload = hi_wrap;
    end else begin
      lo_inc    = lo_tick && ctrl.run_control;
      lo_wrap   = lo_inc && (cnt_lo == sart_pkg::BYTE_MAX);
      hi_inc    = lo_wrap;
      hi_wrap   = hi_inc && (cnt_hi == sart_pkg::BYTE_MAX);
      full_wrap = hi_wrap;
      lo_reload = full_wrap;
      hi_reload = full_wrap;
    end
  end

  sart_byte_cnt u_lo (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .wr_en_in      (wr_cnt_lo),
    .wr_data_in    (w_data),
    .reload_in     (lo_reload),
    .reload_val_in (rl_lo),
    .inc_in        (lo_inc),
    .count_out     (cnt_lo)
  );

  sart_byte_cnt u_hi (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .wr_en_in      (wr_cnt_hi),
    .wr_data_in    (w_data),
    .reload_in     (hi_reload),
    .reload_val_in (rl_hi),
    .inc_in        (hi_inc),
    .count_out     (cnt_hi)
  );

  // write channel: address and data may arrive in either order
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
  assign do_write  = aw_held && w_held && !s_axi_bvalid_out;
  assign aw_mapped = is_mapped(aw_addr);
  assign wr_hit    = do_write && w_strb0 && aw_mapped;
  assign wr_ctrl   = wr_hit && (aw_addr == sart_pkg::OFF_CTRL);
  assign wr_cnt_lo = wr_hit && (aw_addr == sart_pkg::OFF_CNT_LO);
  assign wr_cnt_hi = wr_hit && (aw_addr == sart_pkg::OFF_CNT_HI);
  assign wr_rl_lo  = wr_hit && (aw_addr == sart_pkg::OFF_RL_LO);
  assign wr_rl_hi  = wr_hit && (aw_addr == sart_pkg::OFF_RL_HI);
  assign wr_clksel = wr_hit && (aw_addr == sart_pkg::OFF_CLKSEL);
  assign wr_ien    = wr_hit && (aw_addr == sart_pkg::OFF_IEN);
  assign wr_st     = wr_hit && (aw_addr == sart_pkg::OFF_IRQ_ST);
  assign wr_mask   = wr_hit && (aw_addr == sart_pkg::OFF_IRQ_MASK);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held          <= 1'b0;
      aw_addr          <= sart_pkg::BYTE_ZERO;
      w_held           <= 1'b0;
      w_data           <= sart_pkg::BYTE_ZERO;
      w_strb0          <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= sart_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata_in[7:0];
        w_strb0 <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= aw_mapped ? sart_pkg::RESP_OKAY
                                      : sart_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // read channel: one read outstanding, data straight from registers
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ar_mapped = is_mapped(s_axi_araddr_in);

  always_comb begin
    case (s_axi_araddr_in)
      sart_pkg::OFF_CTRL:     rd_byte = {ctrl[7:2], 1'b0, ctrl[0]};
      sart_pkg::OFF_CNT_LO:   rd_byte = cnt_lo;
      sart_pkg::OFF_CNT_HI:   rd_byte = cnt_hi;
      sart_pkg::OFF_RL_LO:    rd_byte = rl_lo;
      sart_pkg::OFF_RL_HI:    rd_byte = rl_hi;
      sart_pkg::OFF_CLKSEL:   rd_byte = {6'h00, clk_sel};
      sart_pkg::OFF_IEN:      rd_byte = {7'h00, timer_ien};
      sart_pkg::OFF_IRQ_ST:   rd_byte = {6'h00, irq_st};
      sart_pkg::OFF_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default:                rd_byte = sart_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= {sart_pkg::PAD_ZERO, sart_pkg::BYTE_ZERO};
      s_axi_rresp_out  <= sart_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {sart_pkg::PAD_ZERO, rd_byte};
      s_axi_rresp_out  <= ar_mapped ? sart_pkg::RESP_OKAY
                                    : sart_pkg::RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rl_lo     <= sart_pkg::BYTE_ZERO;
      rl_hi     <= sart_pkg::BYTE_ZERO;
      clk_sel   <= sart_pkg::PAIR_ZERO;
      timer_ien <= 1'b0;
      irq_mask  <= sart_pkg::PAIR_ZERO;
    end else begin
      if (wr_rl_lo) begin
        rl_lo <= w_data;
      end
      if (wr_rl_hi) begin
        rl_hi <= w_data;
      end
      if (wr_clksel) begin
        clk_sel <= w_data[1:0];
      end
      if (wr_ien) begin
        timer_ien <= w_data[0];
      end
      if (wr_mask) begin
        irq_mask <= w_data[1:0];
      end
    end
  end

  // flags: a hardware set in the clearing cycle wins over software
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl <= sart_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {w_data[7:2], 1'b0, w_data[0]};
      end
      if (hi_wrap) begin
        ctrl.high_overflow_flag <= 1'b1;
      end
      if (lo_wrap) begin
        ctrl.low_overflow_flag <= 1'b1;
      end
    end
  end

  // sticky interrupt status, write one to clear
  assign irq_set = {hi_wrap, lo_wrap};
  assign w1c = wr_st ? w_data[1:0] : sart_pkg::PAIR_ZERO;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_st <= sart_pkg::PAIR_ZERO;
    end else begin
      irq_st <= irq_set | (irq_st & ~w1c);
    end
  end

  // low wraps reach the line only with the low interrupt enable set
  assign irq_out = timer_ien &&
                   ((irq_st.high && irq_mask.high) ||
                    (irq_st.low && irq_mask.low &&
                     ctrl.low_interrupt_enable));

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  AST_HOLD_STOPPED: assert property (
    !ctrl.split_mode_select && !ctrl.run_control && !wr_cnt_lo &&
    !wr_cnt_hi && !wr_ctrl |=> $stable(cnt_lo) && $stable(cnt_hi) &&
    !$rose(ctrl.high_overflow_flag))
    else $error("count moved while stopped");
  AST_RELOAD16: assert property (
    full_wrap && !wr_cnt_lo && !wr_cnt_hi |=>
    {cnt_hi, cnt_lo} == {$past(rl_hi), $past(rl_lo)} &&
    ctrl.high_overflow_flag)
    else $error("16-bit wrap did not reload");
  AST_IRQ16: assert property (
    full_wrap && timer_ien && irq_mask.high && !wr_ien && !wr_mask
    |=> irq_out)
    else $error("no interrupt on 16-bit wrap");
  AST_LOW_IRQ: assert property (
    lo_wrap && timer_ien && irq_mask.low && ctrl.low_interrupt_enable &&
    !wr_ien && !wr_mask && !wr_ctrl |=> irq_out)
    else $error("no interrupt on low wrap");
  AST_SPLIT_RELOAD: assert property (
    ctrl.split_mode_select && lo_wrap && !wr_cnt_lo |=>
    cnt_lo == $past(rl_lo))
    else $error("low byte did not reload");
  AST_LOW_FREE: assert property (
    ctrl.split_mode_select && !ctrl.run_control && clk_sel.low &&
    !wr_cnt_lo && !wr_clksel && cnt_lo != sart_pkg::BYTE_MAX |=>
    cnt_lo == $past(cnt_lo) + 8'h01)
    else $error("low byte stopped in split mode");
  AST_DIV12: assert property (
    ticks.sys_div12 |=> !ticks.sys_div12 [*8])
    else $error("divide by 12 tick too close");
  AST_SPLIT_HFLAG: assert property (
    ctrl.split_mode_select && hi_wrap && !wr_cnt_hi |=>
    ctrl.high_overflow_flag && cnt_hi == $past(rl_hi))
    else $error("high wrap lost in split mode");
  AST_FLAG_STICKY: assert property (
    !wr_ctrl |=> (ctrl[7:6] & $past(ctrl[7:6])) == $past(ctrl[7:6]))
    else $error("flag cleared by hardware");
  AST_SPLIT_HIGH_IRQ: assert property (
    ctrl.split_mode_select && hi_wrap && timer_ien && irq_mask.high &&
    !wr_ien && !wr_mask ##1 1 |-> irq_out)
    else $error("no interrupt on split high wrap");

  COV_FULL_WRAP:  cover property (full_wrap);
  COV_SPLIT_HIGH: cover property (ctrl.split_mode_select && hi_wrap);
  COV_IRQ_RISE:   cover property ($rose(irq_out));
  COV_EXT_TICK:   cover property (ticks.ext_div8 ##[1:40] ticks.ext_div8);
endmodule : sart_timer
